// file: hdl/ivfc_map.vh
//Function
//- Keep a 16-bit linear-format over-voltage fault threshold and compare the measured input voltage against it to declare an over-voltage fault.
//- Threshold commands move as read/write words and the fault response command moves as a read/write byte.
//- Whatever mode bits 7:6 select, an over-voltage fault pulls the alert line low and sets its status fault bit.
//- Response mode 10 disables the output at once and then follows the restart policy of the retry field.
//- Bits 5:3 of the response byte give how many restart attempts follow a fault shutdown.
//- A retry setting of 000 makes no restart, and the output stays off until the fault is cleared.
//- A retry setting of 111 retries without limit until the output is commanded off, power is lost or another fault shuts it down.
//- The delay between restarts is (bits 2:0 plus one) times 35 ms, from 35 ms to 280 ms.
//- Keep a 16-bit linear-format over-voltage warning threshold that the measured input voltage is checked against.
//- Keep a 16-bit linear-format under-voltage warning threshold and flag a warning when the input falls below it.
//- Keep a 16-bit linear-format under-voltage fault threshold and declare a fault when the input falls below it.
`ifndef IVFC_MAP_VH
`define IVFC_MAP_VH

// Command codes
`define IVFC_CMD_OV_FAULT_THR 8'h55
`define IVFC_CMD_OV_FAULT_ACT 8'h56
`define IVFC_CMD_OV_WARN_THR 8'h57
`define IVFC_CMD_UV_WARN_THR 8'h58
`define IVFC_CMD_UV_FAULT_THR 8'h59

// Reset values; thresholds in linear format with exponent -2, response byte plain
`define IVFC_RST_OV_FAULT_THR 16'hf040
`define IVFC_RST_OV_WARN_THR 16'hf03c
`define IVFC_RST_UV_WARN_THR 16'hf01e
`define IVFC_RST_UV_FAULT_THR 16'hf01c
`define IVFC_RST_OV_FAULT_ACT 8'h80

// Response byte fields
`define IVFC_MODE_HI 7
`define IVFC_MODE_LO 6
`define IVFC_RETRY_HI 5
`define IVFC_RETRY_LO 3
`define IVFC_TIME_HI 2
`define IVFC_TIME_LO 0
`define IVFC_MODE_DISABLE_RETRY 2'h2
`define IVFC_RETRY_NONE 3'h0
`define IVFC_RETRY_ENDLESS 3'h7

// Linear format fields
`define IVFC_LIN_EXP_MSB 15
`define IVFC_LIN_MANT_MSB 10
`define IVFC_LIN_EXP_BIAS 5'h10

// Timing
`define IVFC_CLK_PERIOD_NS 10
`define IVFC_MS_NS 1000000
`define IVFC_MS_CYCLES (`IVFC_MS_NS / `IVFC_CLK_PERIOD_NS)
`define IVFC_RETRY_STEP_MS 6'h23

`endif

// file: hdl/ivfc_tick_div.v
`timescale 1ns/1ns
`default_nettype none
// Millisecond tick; restartable so a retry delay starts on a whole period
module ivfc_tick_div #(
   parameter CYCLES = 100000,
   parameter CW = 24
) (
   // Clock and reset
   input wire ref_clk,
   input wire rstn,
   // Control
   input wire restart,
   // Tick
   output reg tick_reg
);
   reg [CW-1:0] cnt_reg;
   wire at_end = (cnt_reg == CYCLES[CW-1:0] - {{(CW-1){1'b0}}, 1'b1});

   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         cnt_reg <= {CW{1'b0}};
         tick_reg <= 1'b0;
      end else if (restart || at_end) begin
         cnt_reg <= {CW{1'b0}};
         tick_reg <= at_end && !restart;
      end else begin
         cnt_reg <= cnt_reg + {{(CW-1){1'b0}}, 1'b1};
         tick_reg <= 1'b0;
      end
   end
endmodule // ivfc_tick_div
`default_nettype wire

// file: hdl/ivfc_lin_cmp.v
`timescale 1ns/1ns
`default_nettype none
`include "ivfc_map.vh"
// Compares two linear-format values after bringing both to fixed point
module ivfc_lin_cmp (
   // Clock and reset
   input wire ref_clk,
   input wire rstn,
   // Operands
   input wire meas_valid,
   input wire [15:0] meas,
   input wire [15:0] thr,
   // Results
   output reg above_reg,
   output reg below_reg
);
   // Exponent -16..15 becomes a left shift of 0..31
   function signed [42:0] lin_fix;
      input [15:0] v;
      reg [4:0] sh;
      begin
         sh = v[`IVFC_LIN_EXP_MSB:`IVFC_LIN_MANT_MSB+1] ^ `IVFC_LIN_EXP_BIAS;
         lin_fix = {{32{v[`IVFC_LIN_MANT_MSB]}}, v[`IVFC_LIN_MANT_MSB:0]}
                   <<< sh;
      end
   endfunction

   wire signed [42:0] m_fix = lin_fix(meas);
   wire signed [42:0] t_fix = lin_fix(thr);

   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         above_reg <= 1'b0;
         below_reg <= 1'b0;
      end else if (meas_valid) begin
         above_reg <= m_fix > t_fix;
         below_reg <= m_fix < t_fix;
      end
   end
endmodule // ivfc_lin_cmp
`default_nettype wire

// file: hdl/ivfc_top.v
`timescale 1ns/1ns
`default_nettype none
`include "ivfc_map.vh"
module ivfc_top #(
   parameter MS_CYCLES = `IVFC_MS_CYCLES,
   parameter MS_CW = 24
) (
   // Clock and reset
   input wire ref_clk,
   input wire rstn,
   // Decoded management bus transactions
   input wire cmd_valid,
   input wire cmd_write,
   input wire cmd_is_word,
   input wire [7:0] cmd_code,
   input wire [15:0] cmd_wdata,
   output reg rsp_valid_reg,
   output reg rsp_error_reg,
   output reg [15:0] rsp_rdata_reg,
   // Measurement
   input wire vin_meas_valid,
   input wire [15:0] vin_meas,
   // Converter control
   input wire on_cmd,
   input wire other_fault_off,
   input wire clear_faults,
   output reg out_enable_reg,
   // Status bits
   output reg ov_fault_flag_reg,
   output reg ov_warn_flag_reg,
   output reg uv_warn_flag_reg,
   output reg uv_fault_flag_reg,
   // Open-drain alert line
   input wire host_alert_line_in,
   output reg host_alert_line_out_reg,
   output reg host_alert_line_oe_reg
);
   // Sequencer states
   localparam ST_OFF = 4'b0001;
   localparam ST_RUN = 4'b0010;
   localparam ST_HOLD = 4'b0100;
   localparam ST_WAIT = 4'b1000;

   // One-hot select of the addressed command, zero when unmapped
   function [4:0] cmd_sel;
      input [7:0] code;
      begin
         case (code)
            `IVFC_CMD_OV_FAULT_THR: cmd_sel = 5'h01;
            `IVFC_CMD_OV_FAULT_ACT: cmd_sel = 5'h02;
            `IVFC_CMD_OV_WARN_THR: cmd_sel = 5'h04;
            `IVFC_CMD_UV_WARN_THR: cmd_sel = 5'h08;
            `IVFC_CMD_UV_FAULT_THR: cmd_sel = 5'h10;
            default: cmd_sel = 5'h00;
         endcase
      end
   endfunction

   // Only the response command is a byte transfer
   function size_ok;
      input [4:0] sel;
      input is_word;
      begin
         size_ok = (sel[1] != is_word) && (sel != 5'h00);
      end
   endfunction

   reg [15:0] ov_fault_thr_reg;
   reg [7:0] ov_fault_act_reg;
   reg [15:0] ov_warn_thr_reg;
   reg [15:0] uv_warn_thr_reg;
   reg [15:0] uv_fault_thr_reg;
   reg [3:0] state_reg;
   reg [3:0] state_next;
   reg [2:0] attempts_reg;
   reg [2:0] attempts_next;
   reg [8:0] delay_reg;
   reg [8:0] delay_next;
   reg out_enable_next;
   reg [15:0] rdata_next;

   wire [4:0] sel = cmd_sel(cmd_code);
   wire acc_ok = cmd_valid && size_ok(sel, cmd_is_word);
   wire wr_ok = acc_ok && cmd_write;

   wire [1:0] mode = ov_fault_act_reg[`IVFC_MODE_HI:`IVFC_MODE_LO];
   wire [2:0] retry_set = ov_fault_act_reg[`IVFC_RETRY_HI:`IVFC_RETRY_LO];
   wire [2:0] retry_time = ov_fault_act_reg[`IVFC_TIME_HI:`IVFC_TIME_LO];
   // Delay kept in whole milliseconds; 280 fits nine bits
   wire [9:0] delay_prod = ({1'b0, retry_time} + 4'h1)
                           * `IVFC_RETRY_STEP_MS;
   wire [8:0] delay_ms = delay_prod[8:0];

   // Threshold order: 0 ov fault, 1 ov warn, 2 uv warn, 3 uv fault
   wire [63:0] thr_bus = {uv_fault_thr_reg, uv_warn_thr_reg,
                          ov_warn_thr_reg, ov_fault_thr_reg};
   wire [3:0] above;
   wire [3:0] below;

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_cmp
         ivfc_lin_cmp u_cmp (
            .ref_clk(ref_clk),
            .rstn(rstn),
            .meas_valid(vin_meas_valid),
            .meas(vin_meas),
            .thr(thr_bus[gi*16 +: 16]),
            .above_reg(above[gi]),
            .below_reg(below[gi])
         );
      end
   endgenerate

   wire ov_fault_cond = above[0];
   wire ov_warn_cond = above[1];
   wire uv_warn_cond = below[2];
   wire uv_fault_cond = below[3];

   // A shutdown forced by a different fault acts like a commanded off
   wire run_allowed = on_cmd && !other_fault_off;
   wire ov_trip = ov_fault_cond
                  && (mode == `IVFC_MODE_DISABLE_RETRY);
   // Attempts run out; the endless setting never runs out
   wire retries_spent = (retry_set == `IVFC_RETRY_NONE)
                        || ((retry_set != `IVFC_RETRY_ENDLESS)
                        && (attempts_reg >= retry_set));

   // Restarted on entry to the wait, so the first step is a whole one
   wire tick;
   wire div_restart = (state_next == ST_WAIT) && (state_reg != ST_WAIT);

   ivfc_tick_div #(
      .CYCLES(MS_CYCLES),
      .CW(MS_CW)
   ) u_div (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .restart(div_restart),
      .tick_reg(tick)
   );

   // Command registers
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ov_fault_thr_reg <= `IVFC_RST_OV_FAULT_THR;
         ov_fault_act_reg <= `IVFC_RST_OV_FAULT_ACT;
         ov_warn_thr_reg <= `IVFC_RST_OV_WARN_THR;
         uv_warn_thr_reg <= `IVFC_RST_UV_WARN_THR;
         uv_fault_thr_reg <= `IVFC_RST_UV_FAULT_THR;
      end else if (wr_ok) begin
         if (sel[0]) begin
            ov_fault_thr_reg <= cmd_wdata;
         end
         if (sel[1]) begin
            ov_fault_act_reg <= cmd_wdata[7:0];
         end
         if (sel[2]) begin
            ov_warn_thr_reg <= cmd_wdata;
         end
         if (sel[3]) begin
            uv_warn_thr_reg <= cmd_wdata;
         end
         if (sel[4]) begin
            uv_fault_thr_reg <= cmd_wdata;
         end
      end
   end

   // Read mux; byte command reads back in the low byte
   always @* begin
      rdata_next = 16'h0000;
      case (sel)
         5'h01: rdata_next = ov_fault_thr_reg;
         5'h02: rdata_next = {8'h00, ov_fault_act_reg};
         5'h04: rdata_next = ov_warn_thr_reg;
         5'h08: rdata_next = uv_warn_thr_reg;
         5'h10: rdata_next = uv_fault_thr_reg;
         default: rdata_next = 16'h0000;
      endcase
   end

   // A refused access writes nothing and leaves the read data alone
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rsp_valid_reg <= 1'b0;
         rsp_error_reg <= 1'b0;
         rsp_rdata_reg <= 16'h0000;
      end else begin
         rsp_valid_reg <= cmd_valid;
         rsp_error_reg <= cmd_valid && !acc_ok;
         if (cmd_valid && !cmd_write && acc_ok) begin
            rsp_rdata_reg <= rdata_next;
         end
      end
   end

   // Alert read-back is not needed: only this block pulls the line low
   // Sticky status; a new event beats a clear in the same cycle
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ov_fault_flag_reg <= 1'b0;
         ov_warn_flag_reg <= 1'b0;
         uv_warn_flag_reg <= 1'b0;
         uv_fault_flag_reg <= 1'b0;
         host_alert_line_out_reg <= 1'b0;
         host_alert_line_oe_reg <= 1'b0;
      end else begin
         ov_fault_flag_reg <= ov_fault_cond
                              || (ov_fault_flag_reg && !clear_faults);
         ov_warn_flag_reg <= ov_warn_cond
                             || (ov_warn_flag_reg && !clear_faults);
         uv_warn_flag_reg <= uv_warn_cond
                             || (uv_warn_flag_reg && !clear_faults);
         uv_fault_flag_reg <= uv_fault_cond
                              || (uv_fault_flag_reg && !clear_faults);
         host_alert_line_out_reg <= 1'b0;
         // Alert is pulled low while any condition or sticky bit stands
         host_alert_line_oe_reg <= ov_fault_cond || ov_warn_cond
            || uv_warn_cond || uv_fault_cond
            || ((ov_fault_flag_reg || ov_warn_flag_reg
            || uv_warn_flag_reg || uv_fault_flag_reg)
            && !clear_faults);
      end
   end

   // Shutdown and restart sequencer
   always @* begin
      state_next = state_reg;
      attempts_next = attempts_reg;
      delay_next = delay_reg;
      out_enable_next = out_enable_reg;
      case (state_reg)
         ST_OFF: begin
            attempts_next = 3'h0;
            if (run_allowed) begin
               state_next = ST_RUN;
               out_enable_next = 1'b1;
            end
         end
         ST_RUN: begin
            if (!run_allowed) begin
               state_next = ST_OFF;
               out_enable_next = 1'b0;
            end else if (ov_trip) begin
               // Warnings never reach here, only the fault compare
               out_enable_next = 1'b0;
               delay_next = delay_ms;
               if (retries_spent) begin
                  state_next = ST_HOLD;
               end else begin
                  state_next = ST_WAIT;
               end
            end
         end
         ST_WAIT: begin
            if (!run_allowed) begin
               state_next = ST_OFF;
            end else if (tick) begin
               if (delay_reg == 9'h001) begin
                  state_next = ST_RUN;
                  out_enable_next = 1'b1;
                  // Saturating count keeps the endless setting harmless
                  if (attempts_reg != `IVFC_RETRY_ENDLESS) begin
                     attempts_next = attempts_reg + 3'h1;
                  end
               end else begin
                  delay_next = delay_reg - 9'h001;
               end
            end
         end
         ST_HOLD: begin
            if (!run_allowed) begin
               state_next = ST_OFF;
            end else if (!ov_fault_flag_reg && !ov_fault_cond) begin
               state_next = ST_RUN;
               out_enable_next = 1'b1;
               attempts_next = 3'h0;
            end
         end
         default: begin
            state_next = ST_OFF;
            out_enable_next = 1'b0;
         end
      endcase
   end

   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= ST_OFF;
         attempts_reg <= 3'h0;
         delay_reg <= 9'h000;
         out_enable_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         attempts_reg <= attempts_next;
         delay_reg <= delay_next;
         out_enable_reg <= out_enable_next;
      end
   end
endmodule // ivfc_top
`default_nettype wire

// file: test/ivfc_props.sv
`timescale 1ns/1ns
`default_nettype none
module ivfc_props #(
   parameter MS_CYCLES = 10
) (
   // Clock, reset and commands
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic cmd_valid,
   input wire logic cmd_write,
   input wire logic cmd_is_word,
   input wire logic [7:0] cmd_code,
   input wire logic [15:0] cmd_wdata,
   input wire logic rsp_valid_reg,
   input wire logic rsp_error_reg,
   // Converter side
   input wire logic on_cmd,
   input wire logic other_fault_off,
   input wire logic out_enable_reg,
   input wire logic ov_fault_flag_reg,
   input wire logic host_alert_line_out_reg,
   input wire logic host_alert_line_oe_reg
);
   localparam int STEP = 35 * MS_CYCLES;
   reg [7:0] act_reg;
   reg [15:0] off_cnt_reg;
   // Shadow of the action byte, so retry behaviour is judged from the ports
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         act_reg <= 8'h80;
         off_cnt_reg <= 16'h0000;
      end else begin
         if (cmd_valid && cmd_write && !cmd_is_word && cmd_code == 8'h56)
            act_reg <= cmd_wdata[7:0];
         off_cnt_reg <= out_enable_reg ? 16'h0000 : off_cnt_reg + 16'h0001;
      end
   end
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rstn);
   a_rsp_next_cycle:
      assert property (cmd_valid |=> rsp_valid_reg)
      else $error("command left unanswered");
   a_rsp_only_asked:
      assert property (!cmd_valid |=> !rsp_valid_reg)
      else $error("answer without command");
   a_byte_size_err:
      assert property (cmd_valid && cmd_is_word && cmd_code == 8'h56
         |=> rsp_error_reg) else $error("word on action byte accepted");
   a_word_size_ok:
      assert property (cmd_valid && cmd_is_word && cmd_code != 8'h56 &&
         cmd_code >= 8'h55 && cmd_code <= 8'h59 |=> !rsp_error_reg)
      else $error("word on threshold refused");
   a_fault_alerts:
      assert property (ov_fault_flag_reg |-> host_alert_line_oe_reg)
      else $error("fault flag without alert");
   a_alert_pulls_low:
      assert property (host_alert_line_oe_reg |-> !host_alert_line_out_reg)
      else $error("alert driven high");
   a_trip_disables:
      assert property ($rose(ov_fault_flag_reg) && act_reg[7:6] == 2'h2
         |-> !out_enable_reg) else $error("output kept on at trip");
   a_no_retry_holds:
      assert property (ov_fault_flag_reg && act_reg[7:3] == 5'h10
         |-> !out_enable_reg) else $error("restart with retries off");
   a_retry_spacing:
      assert property ($rose(out_enable_reg) && ov_fault_flag_reg |->
         off_cnt_reg + 1 >= STEP * (act_reg[2:0] + 1) &&
         off_cnt_reg <= STEP * (act_reg[2:0] + 1) + 1)
      else $error("restart delay wrong");
   a_warn_no_off:
      assert property ($fell(out_enable_reg) && $past(on_cmd) && on_cmd &&
         !other_fault_off |-> ov_fault_flag_reg)
      else $error("output dropped without fault");
endmodule // ivfc_props
bind ivfc_top ivfc_props #(.MS_CYCLES(MS_CYCLES)) i_props (.ref_clk, .rstn,
   .cmd_valid, .cmd_write, .cmd_is_word, .cmd_code, .cmd_wdata,
   .rsp_valid_reg, .rsp_error_reg, .on_cmd, .other_fault_off,
   .out_enable_reg, .ov_fault_flag_reg, .host_alert_line_out_reg,
   .host_alert_line_oe_reg);
`default_nettype wire

// file: test/ivfc_host.sv
`timescale 1ns/1ns
`default_nettype none
module ivfc_host (
   // Clock
   input wire logic ref_clk,
   // Decoded transactions
   output logic cmd_valid,
   output logic cmd_write,
   output logic cmd_is_word,
   output logic [7:0] cmd_code,
   output logic [15:0] cmd_wdata,
   input wire logic rsp_valid_reg,
   input wire logic rsp_error_reg,
   input wire logic [15:0] rsp_rdata_reg
);
   initial begin
      cmd_valid = 1'b0;
      cmd_write = 1'b0;
      cmd_is_word = 1'b0;
      cmd_code = 8'h00;
      cmd_wdata = 16'h0000;
   end
   // Words and the action byte move whole in one transaction
   task automatic xfer(input logic wr, input logic wd, input logic [7:0] code,
         input logic [15:0] data, output logic [15:0] rd, output logic err);
      int n;
      @(negedge ref_clk);
      cmd_valid = 1'b1;
      cmd_write = wr;
      cmd_is_word = wd;
      cmd_code = code;
      cmd_wdata = data;
      @(negedge ref_clk);
      cmd_valid = 1'b0;
      // Released lines invert so a stale value cannot pass for a good one
      cmd_code = ~code;
      cmd_wdata = ~data;
      n = 0;
      while (rsp_valid_reg !== 1'b1 && n < 4) begin
         @(negedge ref_clk);
         n++;
      end
      rd = rsp_rdata_reg;
      err = (n < 4) ? rsp_error_reg : 1'bx;
   endtask
endmodule // ivfc_host
`default_nettype wire

// file: test/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`include "ivfc_map.vh"
module testbench;
   localparam int MS = 10;
   localparam int STEP = 35 * MS;
   localparam logic [15:0] HIGH = 16'hf044;
   localparam logic [15:0] NORM = 16'hf030;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic cmd_valid, cmd_write, cmd_is_word, rsp_valid_reg, rsp_error_reg;
   logic [7:0] cmd_code;
   logic [15:0] cmd_wdata, rsp_rdata_reg, rd;
   logic [15:0] vin_meas = NORM;
   logic vin_meas_valid = 1'b0;
   logic on_cmd = 1'b0;
   logic other_fault_off = 1'b0;
   logic clear_faults = 1'b0;
   logic out_enable_reg, ov_fault_flag_reg, ov_warn_flag_reg, err;
   logic uv_warn_flag_reg, uv_fault_flag_reg, alert_out, alert_oe;
   int num_errors = 0;
   int total_checks = 0;
   int cycles = 0;
   // Open-drain alert with pull-up
   wire alert_wire = alert_oe ? alert_out : 1'b1;
   always #5 ref_clk = ~ref_clk;
   ivfc_host i_host (.ref_clk, .cmd_valid, .cmd_write, .cmd_is_word,
      .cmd_code, .cmd_wdata, .rsp_valid_reg, .rsp_error_reg, .rsp_rdata_reg);
   ivfc_top #(.MS_CYCLES(MS)) i_dut (.ref_clk, .rstn, .cmd_valid, .cmd_write,
      .cmd_is_word, .cmd_code, .cmd_wdata, .rsp_valid_reg, .rsp_error_reg,
      .rsp_rdata_reg, .vin_meas_valid, .vin_meas, .on_cmd,
      .other_fault_off, .clear_faults, .out_enable_reg,
      .ov_fault_flag_reg, .ov_warn_flag_reg, .uv_warn_flag_reg,
      .uv_fault_flag_reg, .host_alert_line_in(alert_wire),
      .host_alert_line_out_reg(alert_out), .host_alert_line_oe_reg(alert_oe));
   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         close_out;
      end
   end
   task automatic chk(input string what, input logic [15:0] exp,
         input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chkb(input string what, input logic exp, input logic got);
      chk(what, {15'h0, exp}, {15'h0, got});
   endtask
   task automatic near(input int exp, input int got);
      total_checks++;
      if (got < exp - 1 || got > exp + 1) begin
         num_errors++;
         $display("unexpected restart delay: expected %0d seen %0d", exp, got);
      end
   endtask
   task automatic reg_rd(input logic [7:0] code, input logic [15:0] exp);
      i_host.xfer(1'b0, code != 8'h56, code, 16'h0000, rd, err);
      chk("read data", exp, rd);
      chkb("read error", 1'b0, err);
   endtask
   task automatic reg_wr(input logic [7:0] code, input logic [15:0] data);
      i_host.xfer(1'b1, code != 8'h56, code, data, rd, err);
      chkb("write error", 1'b0, err);
   endtask
   // Returns once flags from this sample have landed
   task automatic meas(input logic [15:0] v);
      @(negedge ref_clk);
      vin_meas = v;
      vin_meas_valid = 1'b1;
      @(negedge ref_clk);
      vin_meas_valid = 1'b0;
      repeat (2) @(negedge ref_clk);
   endtask
   task automatic clr;
      @(negedge ref_clk);
      clear_faults = 1'b1;
      @(negedge ref_clk);
      clear_faults = 1'b0;
      @(negedge ref_clk);
   endtask
   task automatic wait_on(output int n);
      n = 0;
      while (out_enable_reg !== 1'b1 && n < 3000) begin
         @(negedge ref_clk);
         n++;
      end
   endtask
   task automatic state(input logic en, input logic flag);
      chkb("output enable", en, out_enable_reg);
      chkb("ov fault flag", flag, ov_fault_flag_reg);
      chkb("alert line", !flag, alert_wire);
   endtask
   task automatic t_regs;
      logic [7:0] codes [5] = '{8'h55, 8'h56, 8'h57, 8'h58, 8'h59};
      logic [15:0] rst [5] = '{`IVFC_RST_OV_FAULT_THR, 16'h0080,
         `IVFC_RST_OV_WARN_THR, `IVFC_RST_UV_WARN_THR, `IVFC_RST_UV_FAULT_THR};
      logic [15:0] wv [5] = '{16'hf050, 16'hab5d, 16'hf04c, 16'hf018, 16'hf014};
      for (int i = 0; i < 5; i++) begin
         reg_rd(codes[i], rst[i]);
         reg_wr(codes[i], wv[i]);
         reg_rd(codes[i], i == 1 ? 16'h005d : wv[i]);
      end
      i_host.xfer(1'b1, 1'b1, 8'h56, 16'h00ff, rd, err);
      chkb("word on byte", 1'b1, err);
      i_host.xfer(1'b1, 1'b0, 8'h55, 16'h0011, rd, err);
      chkb("byte on word", 1'b1, err);
      i_host.xfer(1'b0, 1'b1, 8'h5a, 16'h0000, rd, err);
      chkb("unmapped code", 1'b1, err);
      chk("held read data", 16'hf014, rd);
      reg_rd(8'h56, 16'h005d);
      reg_rd(8'h55, 16'hf050);
      for (int i = 0; i < 5; i++) reg_wr(codes[i], rst[i]);
      $display("register test done");
   endtask
   task automatic t_warn;
      meas(16'hf03e);
      chkb("ov warn flag", 1'b1, ov_warn_flag_reg);
      chkb("alert line", 1'b0, alert_wire);
      chkb("output enable", 1'b1, out_enable_reg);
      chkb("ov fault flag", 1'b0, ov_fault_flag_reg);
      chkb("uv warn flag", 1'b0, uv_warn_flag_reg);
      meas(16'hf01d);
      chkb("uv warn flag", 1'b1, uv_warn_flag_reg);
      chkb("uv fault flag", 1'b0, uv_fault_flag_reg);
      meas(16'hf018);
      chkb("uv fault flag", 1'b1, uv_fault_flag_reg);
      chkb("output enable", 1'b1, out_enable_reg);
      meas(NORM);
      clr;
      chk("flags", 16'h0001, {ov_warn_flag_reg, uv_warn_flag_reg,
         uv_fault_flag_reg, alert_wire});
      $display("warning test done");
   endtask
   task automatic t_modes;
      for (int m = 0; m < 4; m++) begin
         if (m == 2)
            continue;
         reg_wr(8'h56, 16'(m << 6));
         meas(HIGH);
         state(1'b1, 1'b1);
         meas(NORM);
         clr;
      end
      $display("mode test done");
   endtask
   task automatic t_retry_once;
      int n;
      reg_wr(8'h56, 16'h0089);
      meas(HIGH);
      state(1'b0, 1'b1);
      meas(NORM);
      wait_on(n);
      near(2 * STEP, n + 4);
      meas(HIGH);
      repeat (2 * STEP + 40) @(negedge ref_clk);
      state(1'b0, 1'b1);
      meas(NORM);
      clr;
      wait_on(n);
      state(1'b1, 1'b0);
      $display("single retry test done");
   endtask
   task automatic t_no_retry;
      int n;
      reg_wr(8'h56, 16'h0080);
      meas(HIGH);
      meas(NORM);
      repeat (STEP + 40) @(negedge ref_clk);
      state(1'b0, 1'b1);
      clr;
      wait_on(n);
      state(1'b1, 1'b0);
      $display("no retry test done");
   endtask
   task automatic t_endless;
      int n;
      reg_wr(8'h56, 16'h00b8);
      for (int k = 0; k < 3; k++) begin
         meas(HIGH);
         meas(NORM);
         wait_on(n);
         near(STEP, n + 4);
      end
      // Commanded off first, then a shutdown forced by a different fault
      for (int k = 0; k < 2; k++) begin
         meas(HIGH);
         if (k == 0)
            on_cmd = 1'b0;
         else
            other_fault_off = 1'b1;
         meas(NORM);
         repeat (STEP + 40) @(negedge ref_clk);
         state(1'b0, 1'b1);
         clr;
         on_cmd = 1'b1;
         other_fault_off = 1'b0;
         wait_on(n);
         state(1'b1, 1'b0);
      end
      $display("endless retry test done");
   endtask
   initial begin
      repeat (16) @(negedge ref_clk);
      rstn = 1'b1;
      on_cmd = 1'b1;
      repeat (2) @(negedge ref_clk);
      t_regs;
      t_warn;
      t_modes;
      t_retry_once;
      t_no_retry;
      t_endless;
      close_out;
   end
endmodule // testbench
`default_nettype wire
